/* hw/aorm_pkg.sv */
// Constants for the accelerometer output register map.
// Assumes a byte-wide register port with an 8-bit address pointer.
package aorm_pkg;

	localparam int          SAMPLE_W      = 12;
	localparam int          ADDR_W        = 8;

	// Register addresses
	localparam logic [7:0]  A_EVENT       = 8'h00;
	localparam logic [7:0]  A_TEMP        = 8'h01;
	localparam logic [7:0]  A_MAG_LO      = 8'h02;
	localparam logic [7:0]  A_MAG_HI      = 8'h03;
	localparam logic [7:0]  A_X_LO        = 8'h04;
	localparam logic [7:0]  A_X_HI        = 8'h05;
	localparam logic [7:0]  A_Y_LO        = 8'h06;
	localparam logic [7:0]  A_Y_HI        = 8'h07;
	localparam logic [7:0]  A_Z_LO        = 8'h08;
	localparam logic [7:0]  A_Z_HI        = 8'h09;
	localparam logic [7:0]  A_RSVD1       = 8'h0a;
	localparam logic [7:0]  A_QSTAT       = 8'h0b;
	localparam logic [7:0]  A_QX_LO       = 8'h0c;
	localparam logic [7:0]  A_QX_HI       = 8'h0d;
	localparam logic [7:0]  A_QY_LO       = 8'h0e;
	localparam logic [7:0]  A_QY_HI       = 8'h0f;
	localparam logic [7:0]  A_QZ_LO       = 8'h10;
	localparam logic [7:0]  A_QZ_HI       = 8'h11;
	localparam logic [7:0]  A_READ_FMT    = 8'h16;
	localparam logic [7:0]  A_AXIS_SKIP   = 8'h19;
	localparam logic [7:0]  A_STEP        = 8'h01;

	// Reset values
	localparam logic [7:0]  EVENT_RST     = 8'h01;
	localparam logic [7:0]  QSTAT_RST     = 8'h00;
	localparam logic [7:0]  RSVD1_VAL     = 8'h00;
	localparam logic [7:0]  CFG_RST       = 8'h00;

	// read_format_config bit positions
	localparam int          B_FAST_READ   = 0;
	localparam int          B_TEMP_INCL   = 1;
	localparam int          B_ENDIAN      = 2;
	// axis_skip_config bit positions
	localparam int          B_X_SKIP      = 0;
	localparam int          B_Y_SKIP      = 1;
	localparam int          B_Z_SKIP      = 2;
	localparam int          B_MAG_EN      = 3;

	// sample_queue_status layout
	localparam int          B_WMRK        = 7;
	localparam int          B_OVF         = 6;
	localparam int          CNT_W         = 6;

	typedef enum logic [1:0] {
		AORM_IDLE = 2'b01,
		AORM_READ = 2'b10
	} aorm_state_t;

endpackage

/* hw/aorm_seq_if.sv */
// Carrier between the register bank and its pointer sequencer.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface aorm_seq_if;
	logic       fast_read;
	logic       temp_incl;
	logic       mag_en;
	logic [2:0] axis_skip;
	logic [7:0] cur_ptr;
	logic [7:0] next_ptr;

	modport bank (output fast_read, temp_incl, mag_en, axis_skip, cur_ptr, input next_ptr);
	modport seq  (input fast_read, temp_incl, mag_en, axis_skip, cur_ptr, output next_ptr);
endinterface

/* hw/aorm_seq.sv */
// Auto-increment pointer sequencer: next address after a read.
// Assumes configuration bits are stable during a read.
`timescale 1ns/1ps
module aorm_seq (
	aorm_seq_if.seq s
);

	logic xs;
	logic ys;
	logic zs;

	assign xs = s.axis_skip[0];
	assign ys = s.axis_skip[1];
	assign zs = s.axis_skip[2];

	// First enabled current axis from axis index k onward, else wrap
	function automatic logic [7:0] cur_from(input logic [1:0] k, input logic x,
	                                        input logic y, input logic z);
		logic [7:0] r;
		r = aorm_pkg::A_EVENT;
		if (k == 2'd2 && !z) begin
			r = aorm_pkg::A_Z_LO;
		end else if (k == 2'd1) begin
			r = !y ? aorm_pkg::A_Y_LO : (!z ? aorm_pkg::A_Z_LO : aorm_pkg::A_EVENT);
		end else if (k == 2'd0) begin
			r = !x ? aorm_pkg::A_X_LO : (!y ? aorm_pkg::A_Y_LO :
			    (!z ? aorm_pkg::A_Z_LO : aorm_pkg::A_EVENT));
		end
		return r;
	endfunction

	// Queue ring: first enabled axis from index k, circling back
	function automatic logic [7:0] q_from(input logic [1:0] k, input logic [2:0] sk);
		logic [7:0] r;
		logic [1:0] i;
		r = aorm_pkg::A_QX_LO;
		for (int n = 2; n >= 0; n--) begin
			i = 2'((int'(k) + n) % 3);
			if (!sk[i]) begin
				r = 8'(aorm_pkg::A_QX_LO + {5'h00, i, 1'b0});
			end
		end
		return r;
	endfunction

	always_comb begin
		s.next_ptr = 8'(s.cur_ptr + aorm_pkg::A_STEP);
		case (s.cur_ptr)
			aorm_pkg::A_EVENT: begin
				if (s.temp_incl) begin
					s.next_ptr = aorm_pkg::A_TEMP;
				end else if (s.mag_en) begin
					s.next_ptr = aorm_pkg::A_MAG_LO;
				end else begin
					s.next_ptr = cur_from(2'd0, xs, ys, zs);
				end
			end
			aorm_pkg::A_TEMP: begin
				s.next_ptr = s.mag_en ? aorm_pkg::A_MAG_LO : cur_from(2'd0, xs, ys, zs);
			end
			aorm_pkg::A_MAG_LO: begin
				if (s.fast_read) begin
					s.next_ptr = cur_from(2'd0, xs, ys, zs);
				end
			end
			aorm_pkg::A_MAG_HI: s.next_ptr = cur_from(2'd0, xs, ys, zs);
			aorm_pkg::A_X_LO: begin
				if (s.fast_read) begin
					s.next_ptr = cur_from(2'd1, xs, ys, zs);
				end
			end
			aorm_pkg::A_X_HI:  s.next_ptr = cur_from(2'd1, xs, ys, zs);
			aorm_pkg::A_Y_LO: begin
				if (s.fast_read) begin
					s.next_ptr = cur_from(2'd2, xs, ys, zs);
				end
			end
			aorm_pkg::A_Y_HI:  s.next_ptr = cur_from(2'd2, xs, ys, zs);
			aorm_pkg::A_Z_LO: begin
				if (s.fast_read) begin
					s.next_ptr = aorm_pkg::A_EVENT;
				end
			end
			aorm_pkg::A_Z_HI:  s.next_ptr = aorm_pkg::A_EVENT;
			aorm_pkg::A_QSTAT: s.next_ptr = q_from(2'd0, s.axis_skip);
			aorm_pkg::A_QX_LO: begin
				if (s.fast_read) begin
					s.next_ptr = q_from(2'd1, s.axis_skip);
				end
			end
			aorm_pkg::A_QX_HI: s.next_ptr = q_from(2'd1, s.axis_skip);
			aorm_pkg::A_QY_LO: begin
				if (s.fast_read) begin
					s.next_ptr = q_from(2'd2, s.axis_skip);
				end
			end
			aorm_pkg::A_QY_HI: s.next_ptr = q_from(2'd2, s.axis_skip);
			aorm_pkg::A_QZ_LO: begin
				if (s.fast_read) begin
					s.next_ptr = q_from(2'd0, s.axis_skip);
				end
			end
			aorm_pkg::A_QZ_HI: s.next_ptr = q_from(2'd0, s.axis_skip);
			default: s.next_ptr = 8'(s.cur_ptr + aorm_pkg::A_STEP);
		endcase
	end

endmodule

/* hw/aorm_bank.sv */
// Output register bank of the accelerometer with auto-increment reads.
// Assumes a serial front end that decodes frames into the strobes below.
//
// Behaviour
// - Address 00h is a read-only event status register reading 01h after boot.
// - Address 01h returns temperature and is skipped by auto-increment unless included.
// - Addresses 02h/03h carry the 12-bit magnitude split by the endian select.
// - Auto-increment skips both magnitude registers when the magnitude enable is 0.
// - Addresses 04h-09h carry current X/Y/Z samples with the same endian split.
// - A set axis skip bit drops that axis's current and queue registers from bursts.
// - In normal mode the pointer steps by one from each LSB to its MSB and wraps from 09h to 00h.
// - In fast mode an LSB read jumps past its MSB to the next enabled axis LSB or 00h.
// - Address 0Bh is read-only queue status resetting to 00h with watermark and overflow.
// - Queue status holds a 6-bit count and continues to the first enabled queue axis.
// - Addresses 0Ch/0Dh carry the X queue sample; fast mode jumps to 0Eh, 10h or 0Ch.
// - Address 0Ah is reserved reading 00h and steps to 0Bh.
// - Queue bursts circle within 0Ch-11h back to the first enabled queue axis.
// - Endian, temperature inclusion and fast read live in the register at 16h.
// - Axis skip bits live in the register at 19h.
`timescale 1ns/1ps
module aorm_bank #(
	parameter int SAMPLE_W = aorm_pkg::SAMPLE_W
) (
	input  wire logic                          MCLK,
	input  wire logic                          RST_N,
	input  wire logic                          ADDR_LOAD,
	input  wire logic [7:0]                    ADDR_IN,
	input  wire logic                          RD_STB,
	input  wire logic                          WR_STB,
	input  wire logic [7:0]                    WR_DATA,
	input  wire logic [7:0]                    EVENT_IN,
	input  wire logic                          EVENT_LOAD,
	input  wire logic [7:0]                    TEMP_IN,
	input  wire logic [SAMPLE_W-1:0]           MAG_IN,
	input  wire logic [3*SAMPLE_W-1:0]         SAMPLE_IN,
	input  wire logic [3*SAMPLE_W-1:0]         QUEUE_IN,
	input  wire logic                          QUEUE_WMRK,
	input  wire logic                          QUEUE_OVF,
	input  wire logic [aorm_pkg::CNT_W-1:0]    QUEUE_CNT,
	output logic      [7:0]                    RD_DATA,
	output logic                               RD_VALID,
	output logic      [7:0]                    PTR,
	output logic      [7:0]                    READ_FORMAT,
	output logic      [7:0]                    AXIS_SKIP
);

	// Byte split logic is fixed at twelve-bit samples
	if (SAMPLE_W != aorm_pkg::SAMPLE_W) begin : g_width_check
		$error("SAMPLE_W must be 12");
	end

	aorm_seq_if  sq ();
	aorm_pkg::aorm_state_t state;
	logic [7:0]  event_status;
	logic [7:0]  queue_status;
	logic [7:0]  read_format_config;
	logic [7:0]  axis_skip_config;
	logic [7:0]  ptr;
	logic [7:0]  next_rd_data;
	logic        endian_sel;

	////////////////////////////////////////////////////////////////
	// Sequencer hookup

	assign endian_sel   = read_format_config[aorm_pkg::B_ENDIAN];
	assign sq.fast_read = read_format_config[aorm_pkg::B_FAST_READ];
	assign sq.temp_incl = read_format_config[aorm_pkg::B_TEMP_INCL];
	assign sq.mag_en    = axis_skip_config[aorm_pkg::B_MAG_EN];
	assign sq.axis_skip = {axis_skip_config[aorm_pkg::B_Z_SKIP],
	                       axis_skip_config[aorm_pkg::B_Y_SKIP],
	                       axis_skip_config[aorm_pkg::B_X_SKIP]};
	assign sq.cur_ptr   = ptr;

	aorm_seq u_seq (
		.s (sq)
	);

	////////////////////////////////////////////////////////////////
	// Status registers, read-only to the host

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			event_status <= aorm_pkg::EVENT_RST;
		end else if (EVENT_LOAD) begin
			event_status <= EVENT_IN;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			queue_status <= aorm_pkg::QSTAT_RST;
		end else begin
			queue_status                        <= 8'h00;
			queue_status[aorm_pkg::B_WMRK]      <= QUEUE_WMRK;
			queue_status[aorm_pkg::B_OVF]       <= QUEUE_OVF;
			queue_status[aorm_pkg::CNT_W-1:0]   <= QUEUE_CNT;
		end
	end

	////////////////////////////////////////////////////////////////
	// Configuration; only the two config addresses accept writes

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			read_format_config <= aorm_pkg::CFG_RST;
		end else if (WR_STB && ptr == aorm_pkg::A_READ_FMT) begin
			read_format_config <= WR_DATA;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			axis_skip_config <= aorm_pkg::CFG_RST;
		end else if (WR_STB && ptr == aorm_pkg::A_AXIS_SKIP) begin
			axis_skip_config <= WR_DATA;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data mux

	function automatic logic [7:0] lo_byte(input logic [11:0] v, input logic be);
		return be ? v[11:4] : v[7:0];
	endfunction

	function automatic logic [7:0] hi_byte(input logic [11:0] v, input logic be);
		return be ? {4'h0, v[3:0]} : {4'h0, v[11:8]};
	endfunction

	always_comb begin
		next_rd_data = 8'h00;
		case (ptr)
			aorm_pkg::A_EVENT:     next_rd_data = event_status;
			aorm_pkg::A_TEMP:      next_rd_data = TEMP_IN;
			aorm_pkg::A_MAG_LO:    next_rd_data = lo_byte(MAG_IN, endian_sel);
			aorm_pkg::A_MAG_HI:    next_rd_data = hi_byte(MAG_IN, endian_sel);
			aorm_pkg::A_X_LO:      next_rd_data = lo_byte(SAMPLE_IN[11:0], endian_sel);
			aorm_pkg::A_X_HI:      next_rd_data = hi_byte(SAMPLE_IN[11:0], endian_sel);
			aorm_pkg::A_Y_LO:      next_rd_data = lo_byte(SAMPLE_IN[23:12], endian_sel);
			aorm_pkg::A_Y_HI:      next_rd_data = hi_byte(SAMPLE_IN[23:12], endian_sel);
			aorm_pkg::A_Z_LO:      next_rd_data = lo_byte(SAMPLE_IN[35:24], endian_sel);
			aorm_pkg::A_Z_HI:      next_rd_data = hi_byte(SAMPLE_IN[35:24], endian_sel);
			aorm_pkg::A_RSVD1:     next_rd_data = aorm_pkg::RSVD1_VAL;
			aorm_pkg::A_QSTAT:     next_rd_data = queue_status;
			aorm_pkg::A_QX_LO:     next_rd_data = lo_byte(QUEUE_IN[11:0], endian_sel);
			aorm_pkg::A_QX_HI:     next_rd_data = hi_byte(QUEUE_IN[11:0], endian_sel);
			aorm_pkg::A_QY_LO:     next_rd_data = lo_byte(QUEUE_IN[23:12], endian_sel);
			aorm_pkg::A_QY_HI:     next_rd_data = hi_byte(QUEUE_IN[23:12], endian_sel);
			aorm_pkg::A_QZ_LO:     next_rd_data = lo_byte(QUEUE_IN[35:24], endian_sel);
			aorm_pkg::A_QZ_HI:     next_rd_data = hi_byte(QUEUE_IN[35:24], endian_sel);
			aorm_pkg::A_READ_FMT:  next_rd_data = read_format_config;
			aorm_pkg::A_AXIS_SKIP: next_rd_data = axis_skip_config;
			default:               next_rd_data = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Pointer and read handshake
	// Address load wins over a same-cycle read so a new frame starts clean

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ptr <= aorm_pkg::A_EVENT;
		end else if (ADDR_LOAD) begin
			ptr <= ADDR_IN;
		end else if (RD_STB) begin
			ptr <= sq.next_ptr;
		end else if (WR_STB) begin
			ptr <= 8'(ptr + aorm_pkg::A_STEP);
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state    <= aorm_pkg::AORM_IDLE;
			RD_DATA  <= 8'h00;
			RD_VALID <= 1'b0;
		end else begin
			RD_VALID <= 1'b0;
			case (state)
				aorm_pkg::AORM_IDLE: begin
					if (RD_STB && !ADDR_LOAD) begin
						RD_DATA  <= next_rd_data;
						RD_VALID <= 1'b1;
						state    <= aorm_pkg::AORM_READ;
					end
				end
				aorm_pkg::AORM_READ: begin
					if (RD_STB && !ADDR_LOAD) begin
						RD_DATA  <= next_rd_data;
						RD_VALID <= 1'b1;
					end else begin
						state <= aorm_pkg::AORM_IDLE;
					end
				end
				default: state <= aorm_pkg::AORM_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Mirrors for the rest of the device

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			PTR         <= aorm_pkg::A_EVENT;
			READ_FORMAT <= aorm_pkg::CFG_RST;
			AXIS_SKIP   <= aorm_pkg::CFG_RST;
		end else begin
			PTR         <= ptr;
			READ_FORMAT <= read_format_config;
			AXIS_SKIP   <= axis_skip_config;
		end
	end

endmodule

/* verification/aorm_bank_monitor.sv */
// Checker on the ports of the output register bank.
// Assumes configuration is held steady while a burst runs.
`timescale 1ns/1ps
module aorm_bank_monitor #(
	parameter int SAMPLE_W = aorm_pkg::SAMPLE_W
) (
	input wire logic                         MCLK,
	input wire logic                         RST_N,
	input wire logic                         ADDR_LOAD,
	input wire logic [7:0]                   ADDR_IN,
	input wire logic                         RD_STB,
	input wire logic                         WR_STB,
	input wire logic [7:0]                   WR_DATA,
	input wire logic [7:0]                   TEMP_IN,
	input wire logic [SAMPLE_W-1:0]          MAG_IN,
	input wire logic                         QUEUE_WMRK,
	input wire logic                         QUEUE_OVF,
	input wire logic [aorm_pkg::CNT_W-1:0]   QUEUE_CNT,
	input wire logic [7:0]                   RD_DATA,
	input wire logic                         RD_VALID,
	input wire logic [7:0]                   PTR,
	input wire logic [7:0]                   READ_FORMAT,
	input wire logic [7:0]                   AXIS_SKIP
);
////////////////////////////////
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	// Pointer load followed at once by a read
	sequence rd_at(logic [7:0] a);
		ADDR_LOAD && ADDR_IN == a ##1 RD_STB && !ADDR_LOAD;
	endsequence

	a_valid_pulse: assert property (
		RD_VALID == $past(RD_STB && !ADDR_LOAD && RST_N))
		else $error("read valid not one cycle after strobe");
	a_rsvd_zero: assert property (rd_at(8'h0a) |=> RD_DATA == 8'h00)
		else $error("reserved byte not zero");
	a_temp_live: assert property (rd_at(8'h01) |=> RD_DATA == $past(TEMP_IN))
		else $error("temperature byte wrong");
	a_mag_split: assert property (rd_at(8'h02) |=> RD_DATA ==
		($past(READ_FORMAT[2]) ? $past(MAG_IN[11:4]) : $past(MAG_IN[7:0])))
		else $error("magnitude low byte wrong");
	a_qstat_fields: assert property (rd_at(8'h0b) |=> RD_DATA ==
		{$past(QUEUE_WMRK, 2), $past(QUEUE_OVF, 2), $past(QUEUE_CNT, 2)})
		else $error("queue status byte wrong");
	a_skip_default: assert property (ADDR_LOAD && ADDR_IN == 8'h00 &&
		READ_FORMAT == 8'h00 && AXIS_SKIP == 8'h00 ##1 RD_STB && !ADDR_LOAD
		|-> ##2 PTR == 8'h04)
		else $error("status read did not skip to x low");
	a_fast_skip: assert property (ADDR_LOAD && ADDR_IN == 8'h04 &&
		READ_FORMAT == 8'h01 && AXIS_SKIP == 8'h02 ##1 RD_STB && !ADDR_LOAD
		|-> ##2 PTR == 8'h08)
		else $error("fast read did not skip y");
	a_normal_wrap: assert property (ADDR_LOAD && ADDR_IN == 8'h09 &&
		!READ_FORMAT[0] ##1 RD_STB && !ADDR_LOAD |-> ##2 PTR == 8'h00)
		else $error("pointer did not wrap after z high");
	a_fmt_write: assert property (ADDR_LOAD && ADDR_IN == 8'h16 ##1
		WR_STB && !RD_STB && !ADDR_LOAD |-> ##2 READ_FORMAT == $past(WR_DATA, 2))
		else $error("read format not written");
	a_skip_write: assert property (ADDR_LOAD && ADDR_IN == 8'h19 ##1
		WR_STB && !RD_STB && !ADDR_LOAD |-> ##2 AXIS_SKIP == $past(WR_DATA, 2))
		else $error("axis skip not written");
endmodule

bind aorm_bank aorm_bank_monitor #(.SAMPLE_W(SAMPLE_W)) mon_u (
	.MCLK, .RST_N, .ADDR_LOAD, .ADDR_IN, .RD_STB, .WR_STB, .WR_DATA, .TEMP_IN,
	.MAG_IN, .QUEUE_WMRK, .QUEUE_OVF, .QUEUE_CNT, .RD_DATA, .RD_VALID, .PTR,
	.READ_FORMAT, .AXIS_SKIP
);

/* verification/aorm_host_model.sv */
// Host side of the register port: pointer loads, read bursts, writes.
// Assumes strobes are taken on the rising MCLK edge.
`timescale 1ns/1ps
module aorm_host_model (
	input  wire logic       MCLK,
	input  wire logic [7:0] RD_DATA,
	input  wire logic       RD_VALID,
	output logic            ADDR_LOAD,
	output logic      [7:0] ADDR_IN,
	output logic            RD_STB,
	output logic            WR_STB,
	output logic      [7:0] WR_DATA
);
////////////////////////////////
	initial begin
		ADDR_LOAD = 1'b0;
		ADDR_IN = 8'h00;
		RD_STB = 1'b0;
		WR_STB = 1'b0;
		WR_DATA = 8'h00;
	end

	// Released buses show the inverse so stale values never match
	task automatic load(input logic [7:0] a);
		@(negedge MCLK);
		ADDR_LOAD = 1'b1;
		ADDR_IN = a;
		@(negedge MCLK);
		ADDR_LOAD = 1'b0;
		ADDR_IN = ~a;
	endtask

	task automatic burst(input logic [7:0] a, input int n, output logic [7:0] q [$]);
		load(a);
		q = {};
		RD_STB = 1'b1;
		while (q.size() < n) begin
			@(negedge MCLK);
			q.push_back(RD_VALID === 1'b1 ? RD_DATA : 8'hxx);
		end
		RD_STB = 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		load(a);
		WR_STB = 1'b1;
		WR_DATA = d;
		@(negedge MCLK);
		WR_STB = 1'b0;
		WR_DATA = ~d;
	endtask

	task automatic cfg(input logic [7:0] f, input logic [7:0] s);
		wr(8'h16, f);
		wr(8'h19, s);
	endtask
endmodule

/* verification/aorm_bank_test.sv */
// Self-checking bench for the output register bank.
// Assumes the host model drives the port and the checker is bound.
`timescale 1ns/1ps
module aorm_bank_test;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        addr_load, rd_stb, wr_stb, rd_valid;
	logic [7:0]  addr_in, wr_data, rd_data, ptr, read_format, axis_skip;
	logic [7:0]  event_in = 8'h00;
	logic [7:0]  temp_in = 8'h5a;
	logic        queue_wmrk = 1'b1;
	logic        queue_ovf = 1'b0;
	logic        event_load = 1'b0;
	logic [7:0]  q [$];
	int          error_cnt = 0;
	int          tests_run = 0;
	// Address, format, skip, then three expected bytes
	logic [47:0] rows [11] = '{
		48'h00_00_00_01_23_01,
		48'h00_02_08_01_5a_bc,
		48'h02_04_08_ab_0c_12,
		48'h04_01_00_23_56_89,
		48'h04_01_02_23_89_01,
		48'h09_00_00_07_01_23,
		48'h0a_00_00_00_aa_21,
		48'h0b_00_01_aa_54_06,
		48'h10_00_00_87_09_21,
		48'h0c_01_04_21_54_21,
		48'h01_00_09_5a_bc_0a
	};
////////////////////////////////
	always #10 mclk = ~mclk;

	aorm_host_model host_u (.MCLK(mclk), .RD_DATA(rd_data), .RD_VALID(rd_valid),
		.ADDR_LOAD(addr_load), .ADDR_IN(addr_in), .RD_STB(rd_stb), .WR_STB(wr_stb),
		.WR_DATA(wr_data));

	aorm_bank dut_u (.MCLK(mclk), .RST_N(rst_n), .ADDR_LOAD(addr_load),
		.ADDR_IN(addr_in), .RD_STB(rd_stb), .WR_STB(wr_stb), .WR_DATA(wr_data),
		.EVENT_IN(event_in), .EVENT_LOAD(event_load), .TEMP_IN(temp_in),
		.MAG_IN(12'habc), .SAMPLE_IN(36'h789_456_123), .QUEUE_IN(36'h987_654_321),
		.QUEUE_WMRK(queue_wmrk), .QUEUE_OVF(queue_ovf), .QUEUE_CNT(6'h2a), .RD_DATA(rd_data),
		.RD_VALID(rd_valid), .PTR(ptr), .READ_FORMAT(read_format),
		.AXIS_SKIP(axis_skip));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Whole run is about 150 cycles
	initial begin
		#100000;
		error_cnt++;
		test_done();
	end

	initial begin
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		chk("read_format", 8'h00, read_format);
		chk("axis_skip", 8'h00, axis_skip);
		chk("rd_valid", 8'h00, {7'h00, rd_valid});
		$display("reset test done");
		for (int i = 0; i < 11; i++) begin
			host_u.cfg(rows[i][39:32], rows[i][31:24]);
			host_u.burst(rows[i][47:40], 3, q);
			for (int k = 0; k < 3; k++) begin
				chk("burst byte", rows[i][23-8*k -: 8], q[k]);
			end
			$display("row %0d done", i);
		end
		// Ignored writes still step the pointer
		host_u.wr(8'h0a, 8'hff);
		@(negedge mclk);
		chk("ptr after write", 8'h0b, ptr);
		host_u.wr(8'h00, 8'hff);
		host_u.burst(8'h00, 1, q);
		chk("event_status", 8'h01, q[0]);
		host_u.burst(8'h0a, 1, q);
		chk("reserved", 8'h00, q[0]);
		$display("write test done");
		@(negedge mclk);
		event_in = 8'h84;
		event_load = 1'b1;
		@(negedge mclk);
		event_load = 1'b0;
		host_u.burst(8'h00, 1, q);
		chk("event_status", 8'h84, q[0]);
		host_u.burst(8'h16, 1, q);
		chk("read_format_config", 8'h00, q[0]);
		host_u.burst(8'h19, 1, q);
		chk("axis_skip_config", 8'h09, q[0]);
		chk("axis_skip", 8'h09, axis_skip);
		$display("event and config test done");
		// Flip the live inputs so each flag position is really seen
		@(negedge mclk);
		temp_in = 8'h3c;
		queue_wmrk = 1'b0;
		queue_ovf = 1'b1;
		host_u.burst(8'h0b, 1, q);
		chk("sample_queue_status", 8'h6a, q[0]);
		host_u.burst(8'h01, 1, q);
		chk("temperature_out", 8'h3c, q[0]);
		$display("live input test done");
		test_done();
	end
endmodule
